// *** design/demod_loop_pkg.sv ***
package demod_loop_pkg;

   // Register map
   localparam logic [7:0] FREQ_OFFSET_LOOP_CONFIG_ADDR = 8'h19;
   localparam logic [7:0] BIT_SYNC_LOOP_CONFIG_ADDR = 8'h1a;

   // Reset values
   localparam logic [7:0] FREQ_OFFSET_LOOP_CONFIG_RST = 8'h36;
   localparam logic [7:0] BIT_SYNC_LOOP_CONFIG_RST = 8'h6c;

   // Writable bits of the frequency loop register
   localparam logic [7:0] FREQ_OFFSET_LOOP_CONFIG_MASK = 8'h3f;

   // Frequency loop register fields
   localparam int LOOP_FREEZE_UNTIL_CARRIER_POS = 5;
   localparam int FREQ_GAIN_BEFORE_SYNC_POS = 3;
   localparam int FREQ_GAIN_AFTER_SYNC_POS = 2;
   localparam int FREQ_OFFSET_SATURATION_POS = 0;

   // Bit sync register fields
   localparam int CLKREC_INTEGRAL_BEFORE_SYNC_POS = 6;
   localparam int CLKREC_PROPORTIONAL_BEFORE_SYNC_POS = 4;
   localparam int CLKREC_INTEGRAL_AFTER_SYNC_POS = 3;
   localparam int CLKREC_PROPORTIONAL_AFTER_SYNC_POS = 2;
   localparam int DATA_RATE_OFFSET_SATURATION_POS = 0;

   // Gain units: frequency and integral in half steps, proportional whole
   localparam logic [3:0] GAIN_HALF_STEP = 4'h1;
   localparam logic [2:0] GAIN_BASE_STEP = 3'h1;

   // Saturation as a right shift of full scale
   localparam logic [1:0] FREQ_LIMIT_SHIFT_BW8 = 2'h3;
   localparam logic [1:0] FREQ_LIMIT_SHIFT_BW4 = 2'h2;
   localparam logic [1:0] FREQ_LIMIT_SHIFT_BW2 = 2'h1;
   localparam logic [2:0] RATE_LIMIT_SHIFT_3P125 = 3'h5;
   localparam logic [2:0] RATE_LIMIT_SHIFT_6P25 = 3'h4;
   localparam logic [2:0] RATE_LIMIT_SHIFT_12P5 = 3'h3;

   typedef struct packed {
      logic       freeze;
      logic       post_sync;
      logic [3:0] freq_gain_half_k;
      logic       freq_comp_en;
      logic [1:0] freq_limit_shift;
      logic [3:0] integral_gain_half_ki;
      logic [2:0] proportional_gain_kp;
      logic       rate_comp_en;
      logic [2:0] rate_limit_shift;
   } loop_ctrl_s;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_s;

endpackage

// *** design/sync_phase_tracker.sv ***
`timescale 1ns/1ps
module sync_phase_tracker (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Demodulator events
   input wire logic rx_restart,
   input wire logic carrier_sense,
   input wire logic sync_detected,
   // Phase state
   output logic carrier_seen,
   output logic sync_seen
);
   logic carrier_seen_q, carrier_seen_d;
   logic sync_seen_q, sync_seen_d;

   // Set wins over restart so an event in the restart cycle is kept
   always_comb begin
      carrier_seen_d = carrier_seen_q;
      sync_seen_d = sync_seen_q;
      if (rx_restart) begin
         carrier_seen_d = 1'b0;
         sync_seen_d = 1'b0;
      end
      if (carrier_sense) begin
         carrier_seen_d = 1'b1;
      end
      if (sync_detected) begin
         sync_seen_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         carrier_seen_q <= 1'b0;
         sync_seen_q <= 1'b0;
      end else begin
         carrier_seen_q <= carrier_seen_d;
         sync_seen_q <= sync_seen_d;
      end
   end

   assign carrier_seen = carrier_seen_q;
   assign sync_seen = sync_seen_q;
endmodule

// *** design/demod_offset_loop_config.sv ***
`timescale 1ns/1ps
module demod_offset_loop_config
   import demod_loop_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register access
   input wire demod_loop_pkg::reg_req_s reg_req,
   output logic [7:0] rd_data_q,
   output logic rd_valid_q,
   // Demodulator status
   input wire logic rx_restart,
   input wire logic carrier_sense,
   input wire logic sync_detected,
   // Loop control to datapath
   output demod_loop_pkg::loop_ctrl_s loop_ctrl_q
);
   import demod_loop_pkg::*;

   logic [7:0] freq_cfg_q, freq_cfg_d;
   logic [7:0] bsync_cfg_q, bsync_cfg_d;
   logic [7:0] rd_data_d;
   logic rd_valid_d;
   loop_ctrl_s loop_ctrl_d;
   logic carrier_seen;
   logic sync_seen;
   logic in_post_sync;
   logic released;

   // Pre-sync gain code n means (n+1) base steps
   function automatic logic [2:0] pre_gain(input logic [1:0] code);
      pre_gain = {1'b0, code} + GAIN_BASE_STEP;
   endfunction

   function automatic logic [1:0] field2(input logic [7:0] r,
                                         input int pos);
      field2 = r[pos +: 2];
   endfunction

   // Half steps 2, 4, 6 or 8; four bits so 4K does not wrap
   function automatic logic [3:0] pre_gain_half(input logic [1:0] code);
      pre_gain_half = {pre_gain(code), 1'b0};
   endfunction

   // Frequency limit as a right shift of the channel bandwidth
   function automatic logic [1:0] freq_limit(input logic [1:0] code);
      case (code)
         2'h1: begin
            freq_limit = FREQ_LIMIT_SHIFT_BW8;
         end
         2'h2: begin
            freq_limit = FREQ_LIMIT_SHIFT_BW4;
         end
         2'h3: begin
            freq_limit = FREQ_LIMIT_SHIFT_BW2;
         end
         default: begin
            freq_limit = 2'h0;
         end
      endcase
   endfunction

   // Rate limit as a right shift of the nominal data rate
   function automatic logic [2:0] rate_limit(input logic [1:0] code);
      case (code)
         2'h1: begin
            rate_limit = RATE_LIMIT_SHIFT_3P125;
         end
         2'h2: begin
            rate_limit = RATE_LIMIT_SHIFT_6P25;
         end
         2'h3: begin
            rate_limit = RATE_LIMIT_SHIFT_12P5;
         end
         default: begin
            rate_limit = 3'h0;
         end
      endcase
   endfunction

   sync_phase_tracker u_phase (
      .clk(clk),
      .rst_n(rst_n),
      .rx_restart(rx_restart),
      .carrier_sense(carrier_sense),
      .sync_detected(sync_detected),
      .carrier_seen(carrier_seen),
      .sync_seen(sync_seen)
   );

   // Register file
   always_comb begin
      freq_cfg_d = freq_cfg_q;
      bsync_cfg_d = bsync_cfg_q;
      if (reg_req.wr) begin
         case (reg_req.addr)
            FREQ_OFFSET_LOOP_CONFIG_ADDR: begin
               freq_cfg_d = reg_req.wdata & FREQ_OFFSET_LOOP_CONFIG_MASK;
            end
            BIT_SYNC_LOOP_CONFIG_ADDR: begin
               bsync_cfg_d = reg_req.wdata;
            end
            default: begin
               freq_cfg_d = freq_cfg_q;
            end
         endcase
      end
   end

   // Read path apart: a write in the read cycle leaves old data
   always_comb begin
      rd_valid_d = reg_req.rd;
      rd_data_d = rd_data_q;
      if (reg_req.rd) begin
         case (reg_req.addr)
            FREQ_OFFSET_LOOP_CONFIG_ADDR: begin
               rd_data_d = freq_cfg_q & FREQ_OFFSET_LOOP_CONFIG_MASK;
            end
            BIT_SYNC_LOOP_CONFIG_ADDR: begin
               rd_data_d = bsync_cfg_q;
            end
            default: begin
               rd_data_d = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         freq_cfg_q <= FREQ_OFFSET_LOOP_CONFIG_RST;
         bsync_cfg_q <= BIT_SYNC_LOOP_CONFIG_RST;
      end else begin
         freq_cfg_q <= freq_cfg_d;
         bsync_cfg_q <= bsync_cfg_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_q <= 8'h00;
         rd_valid_q <= 1'b0;
      end else begin
         rd_data_q <= rd_data_d;
         rd_valid_q <= rd_valid_d;
      end
   end

   // Same-cycle events count, saving one cycle of lag
   // restart masks latched phase
   assign in_post_sync = sync_detected | (sync_seen & ~rx_restart);
   assign released = carrier_sense | (carrier_seen & ~rx_restart);

   // Loop control
   always_comb begin
      loop_ctrl_d = '0;
      loop_ctrl_d.post_sync = in_post_sync;
      loop_ctrl_d.freeze = freq_cfg_q[LOOP_FREEZE_UNTIL_CARRIER_POS]
                           & ~released;

      loop_ctrl_d.freq_gain_half_k =
         pre_gain_half(field2(freq_cfg_q, FREQ_GAIN_BEFORE_SYNC_POS));
      if (in_post_sync && freq_cfg_q[FREQ_GAIN_AFTER_SYNC_POS]) begin
         loop_ctrl_d.freq_gain_half_k = GAIN_HALF_STEP;
      end

      loop_ctrl_d.freq_limit_shift =
         freq_limit(field2(freq_cfg_q, FREQ_OFFSET_SATURATION_POS));
      loop_ctrl_d.freq_comp_en =
         |field2(freq_cfg_q, FREQ_OFFSET_SATURATION_POS);

      loop_ctrl_d.integral_gain_half_ki =
         pre_gain_half(field2(bsync_cfg_q, CLKREC_INTEGRAL_BEFORE_SYNC_POS));
      if (in_post_sync && bsync_cfg_q[CLKREC_INTEGRAL_AFTER_SYNC_POS]) begin
         loop_ctrl_d.integral_gain_half_ki = GAIN_HALF_STEP;
      end

      loop_ctrl_d.proportional_gain_kp =
         pre_gain(field2(bsync_cfg_q, CLKREC_PROPORTIONAL_BEFORE_SYNC_POS));
      if (in_post_sync
          && bsync_cfg_q[CLKREC_PROPORTIONAL_AFTER_SYNC_POS]) begin
         loop_ctrl_d.proportional_gain_kp = GAIN_BASE_STEP;
      end

      loop_ctrl_d.rate_limit_shift =
         rate_limit(field2(bsync_cfg_q, DATA_RATE_OFFSET_SATURATION_POS));
      loop_ctrl_d.rate_comp_en =
         |field2(bsync_cfg_q, DATA_RATE_OFFSET_SATURATION_POS);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         loop_ctrl_q <= '0;
      end else begin
         loop_ctrl_q <= loop_ctrl_d;
      end
   end
endmodule

// *** testbench/demod_offset_loop_config_sva.sv ***
`timescale 1ns/1ps
module demod_offset_loop_config_sva
   import demod_loop_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Watched ports
   input wire demod_loop_pkg::reg_req_s reg_req,
   input wire logic [7:0] rd_data_q,
   input wire logic rd_valid_q,
   input wire logic rx_restart,
   input wire logic carrier_sense,
   input wire logic sync_detected,
   input wire demod_loop_pkg::loop_ctrl_s loop_ctrl_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   rsvd_read_a: assert property (
      reg_req.rd && reg_req.addr == 8'h19 |=> rd_data_q[7:6] == 2'h0)
      else $error("reserved bits read nonzero");
   sync_post_a: assert property (
      sync_detected |=> loop_ctrl_q.post_sync)
      else $error("sync did not select post gains");
   restart_pre_a: assert property (
      rx_restart && !sync_detected |=> !loop_ctrl_q.post_sync)
      else $error("restart kept post gains");
   post_hold_a: assert property (
      loop_ctrl_q.post_sync && !rx_restart |=> loop_ctrl_q.post_sync)
      else $error("post gains dropped early");
   carrier_free_a: assert property (
      carrier_sense |=> !loop_ctrl_q.freeze)
      else $error("loops still frozen after carrier");
   pre_gain_a: assert property (
      $past(rst_n) && !loop_ctrl_q.post_sync |->
      loop_ctrl_q.freq_gain_half_k != 4'h0 && !loop_ctrl_q.freq_gain_half_k[0]
      && loop_ctrl_q.integral_gain_half_ki != 4'h0
      && loop_ctrl_q.proportional_gain_kp != 3'h0)
      else $error("pre-sync gain out of range");
   freq_en_a: assert property (
      loop_ctrl_q.freq_comp_en == (loop_ctrl_q.freq_limit_shift != 2'h0))
      else $error("frequency limit and enable disagree");
   rate_en_a: assert property (
      loop_ctrl_q.rate_comp_en == (loop_ctrl_q.rate_limit_shift != 3'h0))
      else $error("rate limit and enable disagree");
   cover property (sync_detected ##1 loop_ctrl_q.post_sync);
   cover property (carrier_sense && loop_ctrl_q.freeze);
   cover property (reg_req.wr && reg_req.addr == 8'h19);
endmodule

// *** testbench/demod_offset_loop_config_tb.sv ***
`timescale 1ns/1ps
module demod_offset_loop_config_tb;
   import demod_loop_pkg::*;
   localparam logic [7:0] FA = FREQ_OFFSET_LOOP_CONFIG_ADDR;
   localparam logic [7:0] BA = BIT_SYNC_LOOP_CONFIG_ADDR;
   logic clk = 0, rst_n = 0, rx_restart = 0, carrier_sense = 0;
   logic sync_detected = 0, post = 0, cs = 0;
   reg_req_s reg_req = '0;
   logic [7:0] rd_data_q, f_q = 8'h36, b_q = 8'h6c;
   logic rd_valid_q;
   loop_ctrl_s loop_ctrl_q;
   int bad_count = 0, comparisons = 0;
   always #5 clk = ~clk;
   demod_offset_loop_config DUT (.clk(clk), .rst_n(rst_n),
      .reg_req(reg_req), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
      .rx_restart(rx_restart), .carrier_sense(carrier_sense),
      .sync_detected(sync_detected), .loop_ctrl_q(loop_ctrl_q));
   task automatic cmp(string n, logic [7:0] e, logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task end_of_test;
      if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk) #1 reg_req = '{1'b1, 1'b0, a, d};
      @(posedge clk) #1 reg_req = '0;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge clk) #1 reg_req = '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk) #1 reg_req = '0;
      cmp("rd_valid", 8'h01, {7'h0, rd_valid_q});
      cmp("rd_data", e, rd_data_q);
   endtask
   task automatic ev(logic r, logic c, logic s);
      @(posedge clk) #1 {rx_restart, carrier_sense, sync_detected} = {r, c, s};
      @(posedge clk) #1 {rx_restart, carrier_sense, sync_detected} = 3'h0;
      if (c) cs = 1;
      else if (r) cs = 0;
      if (s) post = 1;
      else if (r) post = 0;
   endtask
   // Gains kept one bit wider so 4K is not lost to wrap
   task automatic chk;
      logic [3:0] fk, ik, pk;
      @(posedge clk) #1;
      fk = (post && f_q[2]) ? 4'h1 : {1'b0, f_q[4:3], 1'b0} + 4'h2;
      ik = (post && b_q[3]) ? 4'h1 : {1'b0, b_q[7:6], 1'b0} + 4'h2;
      pk = (post && b_q[2]) ? 4'h1 : {2'h0, b_q[5:4]} + 4'h1;
      cmp("freeze", {7'h0, f_q[5] & ~cs}, {7'h0, loop_ctrl_q.freeze});
      cmp("post", {7'h0, post}, {7'h0, loop_ctrl_q.post_sync});
      cmp("freq_k", 8'(fk), 8'(loop_ctrl_q.freq_gain_half_k));
      cmp("freq_en", 8'(|f_q[1:0]), 8'(loop_ctrl_q.freq_comp_en));
      cmp("freq_lim", (f_q[1:0] == 2'h0) ? 8'h0 : 8'h4 - f_q[1:0],
         {6'h0, loop_ctrl_q.freq_limit_shift});
      cmp("int_k", 8'(ik),
         8'(loop_ctrl_q.integral_gain_half_ki));
      cmp("prop_k", 8'(pk),
         8'(loop_ctrl_q.proportional_gain_kp));
      cmp("rate_en", 8'(|b_q[1:0]), 8'(loop_ctrl_q.rate_comp_en));
      cmp("rate_lim", (b_q[1:0] == 2'h0) ? 8'h0 : 8'h6 - b_q[1:0],
         {5'h0, loop_ctrl_q.rate_limit_shift});
   endtask
   task t_regs;
      rd(FA, 8'h36);
      rd(BA, 8'h6c);
      rd(8'h1b, 8'h00);
      chk;
      wr(FA, 8'hff);
      f_q = 8'h3f;
      rd(FA, 8'h3f);
   endtask
   task t_codes;
      for (int i = 0; i < 4; i++) begin
         f_q = {3'h0, 2'(i), 1'b0, 2'(i)};
         b_q = {2'(i), 2'(3 - i), 2'h0, 2'(i)};
         wr(FA, f_q);
         wr(BA, b_q);
         chk;
      end
   endtask
   task automatic t_sync(logic [7:0] f, logic [7:0] b);
      f_q = f;
      b_q = b;
      wr(FA, f);
      wr(BA, b);
      ev(1, 0, 0);
      chk;
      ev(0, 1, 0);
      chk;
      ev(0, 0, 1);
      chk;
      ev(1, 0, 0);
      chk;
   endtask
   task t_rst;
      ev(0, 0, 1);
      #2 rst_n = 0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1;
      {f_q, b_q, post, cs} = {8'h36, 8'h6c, 2'h0};
      chk;
      rd(BA, 8'h6c);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      #1 rst_n = 1;
      t_regs;
      t_codes;
      t_sync(8'h3f, 8'hec);
      t_sync(8'h2a, 8'h50);
      t_rst;
      end_of_test;
   end
   initial begin
      #20000;
      bad_count++;
      end_of_test;
   end
endmodule
bind demod_offset_loop_config demod_offset_loop_config_sva chk (.clk(clk),
   .rst_n(rst_n), .reg_req(reg_req), .rd_data_q(rd_data_q),
   .rd_valid_q(rd_valid_q), .rx_restart(rx_restart),
   .carrier_sense(carrier_sense), .sync_detected(sync_detected),
   .loop_ctrl_q(loop_ctrl_q));
